// File: hw/data_memory_access_unit.sv
// data memory access unit: internal 256-byte space, special registers, on-chip
// expanded RAM and the external memory interface with programmable timing
// assumes a core that issues one request at a time and waits while busy is high
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module data_memory_access_unit (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // core request
  input  wire logic              req_valid,
  input  wire dmau_pkg::mem_req_t req,
  output logic                   busy,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data,
  // register port into special-register space
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  // external pins
  input  wire logic [7:0]        p0_in,
  output dmau_pkg::ext_pins_t    pins
);

  // ==========================================
  // state
  typedef struct packed {
    logic [7:0]       aux;
    logic [7:0]       timing;
    logic [7:0]       program_status_word;
    logic [7:0]       p0_latch;
    logic [7:0]       p2_latch;
    dmau_pkg::phase_t ph;
    logic [2:0]       cnt;
    dmau_pkg::mem_req_t cur;
    logic             busy;
    logic             rsp_valid;
    logic [7:0]       rsp_data;
    logic [7:0]       reg_rdata;
    logic [7:0]       p0_s1;
    logic [7:0]       p0_s2;
    logic [1:0]       cap_dly;
    logic [7:0]       xdat;
    dmau_pkg::ext_pins_t pins;
  } state_t;

  // ==========================================
  // reset values
  // pins idle: bus released, latch strobe low, both strobes high
  localparam dmau_pkg::ext_pins_t pins_reset = '{
    p0_oe:             1'b0,
    p0_out:            dmau_pkg::port_reset,
    p2_out:            dmau_pkg::port_reset,
    ale:               1'b0,
    read_strobe_n:     1'b1,
    write_strobe_n:    1'b1,
    strobe_fast_drive: 1'b0
  };

  // whole state after reset, constants only
  localparam state_t state_reset = '{
    aux:       dmau_pkg::aux_reset,
    timing:    dmau_pkg::timing_reset,
    program_status_word:       8'h00,
    p0_latch:  dmau_pkg::port_reset,
    p2_latch:  dmau_pkg::port_reset,
    ph:        dmau_pkg::st_idle,
    cnt:       3'h0,
    cur:       '0,
    busy:      1'b0,
    rsp_valid: 1'b0,
    rsp_data:  8'h00,
    reg_rdata: 8'h00,
    p0_s1:     8'h00,
    p0_s2:     8'h00,
    cap_dly:   2'b00,
    xdat:      8'h00,
    pins:      pins_reset
  };

  // ==========================================
  // storage
  // internal RAM: lower 128 bytes and the separate upper 128 bytes
  logic [7:0] iram [0:255];
  // on-chip expanded RAM reached by move-external accesses
  logic [7:0] onchip_expanded_ram [0:dmau_pkg::onchip_expanded_ram_depth-1];

  // registered state and its next value
  state_t     s;
  state_t     next_s;

  // write port of the internal RAM
  logic       iram_we;
  logic [7:0] iram_wa;
  logic [7:0] iram_wd;

  // write port of the expanded RAM
  logic       onchip_expanded_ram_we;
  logic [9:0] onchip_expanded_ram_wa;
  logic [7:0] onchip_expanded_ram_wd;

  // ==========================================
  // special-register helpers
  // read one special register; unmapped addresses read zero
  function automatic logic [7:0] sfr_rd(state_t st, logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      dmau_pkg::aux_addr: begin
        r = st.aux;
      end
      dmau_pkg::timing_addr: begin
        r = st.timing;
      end
      dmau_pkg::psw_addr: begin
        r = st.program_status_word;
      end
      dmau_pkg::p0_addr: begin
        r = st.p0_latch;
      end
      dmau_pkg::p2_addr: begin
        r = st.p2_latch;
      end
      default: begin
        r = 8'h00;
      end
    endcase
    return r;
  endfunction : sfr_rd

  // write one special register; read-only bits stay zero through the masks
  function automatic state_t sfr_wr(state_t st, logic [7:0] a, logic [7:0] d);
    state_t r;
    r = st;
    case (a)
      dmau_pkg::aux_addr: begin
        r.aux = d & dmau_pkg::aux_wmask;
      end
      dmau_pkg::timing_addr: begin
        r.timing = d & dmau_pkg::timing_wmask;
      end
      dmau_pkg::psw_addr: begin
        r.program_status_word = d;
      end
      dmau_pkg::p0_addr: begin
        r.p0_latch = d;
      end
      dmau_pkg::p2_addr: begin
        r.p2_latch = d;
      end
      default: begin
        r = st;
      end
    endcase
    return r;
  endfunction : sfr_wr

  // ==========================================
  // next-state logic
  // decodes the core request, runs the external cycle, serves the register port
  always_comb begin
    logic [7:0]  ia;
    logic        to_sfr;
    logic [7:0]  rbyte;
    logic [7:0]  wbyte;
    logic [2:0]  bpos;
    logic [15:0] xa;
    logic        on_chip;
    logic [2:0]  sh_cnt;
    logic [2:0]  lw_cnt;
    logic [2:0]  sw_cnt;
    logic        mux_mode;
    ia       = 8'h00;
    to_sfr   = 1'b0;
    rbyte    = 8'h00;
    wbyte    = 8'h00;
    bpos     = 3'h0;
    xa       = 16'h0000;
    on_chip  = 1'b0;
    // timing fields, as counter start values (code, so code plus one cycles)
    sh_cnt   = {2'b00, s.timing[dmau_pkg::sh_bit]};
    lw_cnt   = {1'b0, s.timing[dmau_pkg::lw_lsb +: 2]};
    sw_cnt   = s.timing[dmau_pkg::sw_lsb +: 3];
    mux_mode = !s.timing[dmau_pkg::mode_bit];
    iram_we  = 1'b0;
    iram_wa  = 8'h00;
    iram_wd  = 8'h00;
    onchip_expanded_ram_we  = 1'b0;
    onchip_expanded_ram_wa  = 10'h000;
    onchip_expanded_ram_wd  = 8'h00;

    // defaults: one-cycle pulses fall, pin input moves down the synchroniser
    next_s           = s;
    next_s.rsp_valid = 1'b0;
    next_s.reg_rdata = 8'h00;
    next_s.p0_s1     = p0_in;
    next_s.p0_s2     = s.p0_s1;
    next_s.cap_dly   = {s.cap_dly[0], 1'b0};
    // read data of an external cycle, taken two clocks after the strobe ends
    if (s.cap_dly[1]) begin
      next_s.xdat = s.p0_s2;
    end

    // internal byte address of the request
    if (req.is_reg) begin
      // working register of the bank chosen in the status word
      ia     = {3'b000, s.program_status_word[dmau_pkg::bank_lsb +: 2], req.addr[2:0]};
      to_sfr = 1'b0;
    end else if (req.is_bit) begin
      bpos = req.addr[2:0];
      if (req.addr[7] == 1'b0) begin
        // bit area above the register banks
        ia     = dmau_pkg::bit_area_base + {4'h0, req.addr[6:3]};
        to_sfr = 1'b0;
      end else begin
        // special registers whose address ends in 0 or 8
        ia     = {req.addr[7:3], 3'b000};
        to_sfr = 1'b1;
      end
    end else begin
      // upper half goes to registers when direct, to upper RAM when indirect
      ia     = req.addr[7:0];
      to_sfr = req.direct && (req.addr[7:0] >= dmau_pkg::upper_base);
    end
    rbyte       = to_sfr ? sfr_rd(s, ia) : iram[ia];
    wbyte       = rbyte;
    wbyte[bpos] = req.bit_val;

    // external address: pointer, or page latch beside an 8-bit address
    xa      = req.wide ? req.addr : {s.p2_latch, req.addr[7:0]};
    on_chip = !s.aux[dmau_pkg::sel_bit] && (xa <= dmau_pkg::onchip_expanded_ram_top);

    case (s.ph)
      dmau_pkg::st_idle: begin
        if (req_valid) begin
          if (!req.ext) begin
            // internal access answers in the next cycle
            next_s.rsp_valid = 1'b1;
            next_s.rsp_data  = 8'h00;
            if (req.wr) begin
              if (to_sfr) begin
                next_s = sfr_wr(next_s, ia, req.is_bit ? wbyte : req.wdata);
              end else begin
                iram_we = 1'b1;
                iram_wa = ia;
                iram_wd = req.is_bit ? wbyte : req.wdata;
              end
            end else if (req.is_bit) begin
              next_s.rsp_data = {7'h00, rbyte[bpos]};
            end else begin
              next_s.rsp_data = rbyte;
            end
          end else if (on_chip) begin
            // on-chip expanded RAM: no pin moves at all
            next_s.rsp_valid = 1'b1;
            next_s.rsp_data  = 8'h00;
            if (req.wr) begin
              onchip_expanded_ram_we = 1'b1;
              onchip_expanded_ram_wa = xa[9:0];
              onchip_expanded_ram_wd = req.wdata;
            end else begin
              next_s.rsp_data = onchip_expanded_ram[xa[9:0]];
            end
          end else begin
            // external cycle starts; port 0 latch is overwritten with ones
            next_s.cur         = req;
            next_s.cur.addr    = xa;
            next_s.p0_latch    = dmau_pkg::port_reset;
            next_s.busy        = 1'b1;
            next_s.pins.p2_out = xa[15:8];
            if (mux_mode) begin
              // low address on port 0 while the latch strobe is high
              next_s.ph          = dmau_pkg::st_ale_hi;
              next_s.cnt         = lw_cnt;
              next_s.pins.ale    = 1'b1;
              next_s.pins.p0_oe  = 1'b1;
              next_s.pins.p0_out = xa[7:0];
            end else begin
              // no address phase: straight to the strobe setup
              next_s.ph          = dmau_pkg::st_setup;
              next_s.cnt         = sh_cnt;
              next_s.pins.p0_oe  = req.wr;
              next_s.pins.p0_out = req.wr ? req.wdata : dmau_pkg::port_reset;
            end
          end
        end
      end

      dmau_pkg::st_ale_hi: begin
        // latch strobe high phase
        if (s.cnt == 3'h0) begin
          next_s.ph       = dmau_pkg::st_ale_lo;
          next_s.cnt      = lw_cnt;
          next_s.pins.ale = 1'b0;
        end else begin
          next_s.cnt = s.cnt - 3'h1;
        end
      end

      dmau_pkg::st_ale_lo: begin
        // address still on port 0 so the latch holds it after the fall
        if (s.cnt == 3'h0) begin
          next_s.ph          = dmau_pkg::st_setup;
          next_s.cnt         = sh_cnt;
          next_s.pins.p0_oe  = s.cur.wr;
          next_s.pins.p0_out = s.cur.wr ? s.cur.wdata : dmau_pkg::port_reset;
        end else begin
          next_s.cnt = s.cnt - 3'h1;
        end
      end

      dmau_pkg::st_setup: begin
        // data stands on port 0 before a write strobe falls
        if (s.cnt == 3'h0) begin
          next_s.ph                  = dmau_pkg::st_strobe;
          next_s.cnt                 = sw_cnt;
          next_s.pins.read_strobe_n  = s.cur.wr;
          next_s.pins.write_strobe_n = !s.cur.wr;
        end else begin
          next_s.cnt = s.cnt - 3'h1;
        end
      end

      dmau_pkg::st_strobe: begin
        // strobe low; port 0 seen at its release edge
        if (s.cnt == 3'h0) begin
          next_s.ph                  = dmau_pkg::st_hold;
          next_s.cnt                 = sh_cnt;
          next_s.pins.read_strobe_n  = 1'b1;
          next_s.pins.write_strobe_n = 1'b1;
          next_s.cap_dly             = {s.cap_dly[0], 1'b1};
        end else begin
          next_s.cnt = s.cnt - 3'h1;
        end
      end

      dmau_pkg::st_hold: begin
        // write data kept past the strobe release
        if (s.cnt == 3'h0) begin
          next_s.ph          = dmau_pkg::st_done;
          next_s.pins.p0_oe  = 1'b0;
          next_s.pins.p2_out = s.p2_latch;
        end else begin
          next_s.cnt = s.cnt - 3'h1;
        end
      end

      dmau_pkg::st_done: begin
        // answer the core; read data may arrive from the synchroniser now
        next_s.ph        = dmau_pkg::st_idle;
        next_s.busy      = 1'b0;
        next_s.rsp_valid = 1'b1;
        if (s.cur.wr) begin
          next_s.rsp_data = 8'h00;
        end else if (s.cap_dly[1]) begin
          next_s.rsp_data = s.p0_s2;
        end else begin
          next_s.rsp_data = s.xdat;
        end
      end

      default: begin
        next_s.ph   = dmau_pkg::st_idle;
        next_s.busy = 1'b0;
      end
    endcase

    // register port last, so software wins a clash with the core
    if (reg_wr) begin
      next_s = sfr_wr(next_s, reg_addr, reg_wdata);
    end
    if (reg_rd) begin
      next_s.reg_rdata = sfr_rd(s, reg_addr);
    end
    // drive strength option follows its control bit
    next_s.pins.strobe_fast_drive = next_s.aux[dmau_pkg::fast_bit];
  end

  // ==========================================
  // state register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= state_reset;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // memory arrays, no reset: contents are undefined until written
  always_ff @(posedge mclk) begin
    if (iram_we) begin
      iram[iram_wa] <= iram_wd;
    end
    if (onchip_expanded_ram_we) begin
      onchip_expanded_ram[onchip_expanded_ram_wa] <= onchip_expanded_ram_wd;
    end
  end

  // ==========================================
  // outputs, straight from the state register
  assign busy      = s.busy;
  assign rsp_valid = s.rsp_valid;
  assign rsp_data  = s.rsp_data;
  assign reg_rdata = s.reg_rdata;
  assign pins      = s.pins;

endmodule : data_memory_access_unit

// File: shared/dmau_pkg.sv
// package for the data memory access unit: offsets, fields, reset values, types
// assumes one system clock and a plain register port on the special-register space
//
// Functional notes
// - direct address above 7FH goes to special registers, indirect to upper RAM
// - lowest 32 bytes are 4 banks of 8 working registers
// - bank chosen by two bank-select bits of the program status word
// - 16 bytes above banks are bit-addressable, bit addresses 00H to 7FH
// - lower 128 bytes direct or indirect, upper 128 indirect only
// - special registers direct only; bit-addressable when address ends 0H or 8H
// - external access uses 16-bit pointer or 8-bit indirect address
// - 8-bit external cycle keeps Port 2 latch on Port 2 pins
// - 16-bit external cycle drives high address on Port 2 whole cycle
// - multiplexed mode: low address then data on Port 0, valid at latch fall
// - write data on Port 0 before write strobe until after its release
// - read samples Port 0 just before read strobe release
// - every external access sets the Port 0 latch to all ones
// - read and write strobes are active low
// - select bit 0 sends 0000H-03FFH to on-chip RAM, 1 sends all external
// - on-chip RAM access leaves ports and strobes unchanged
// - interface mode bit 7: 0 multiplexed, 1 no address phase
// - latch high and low phases last code plus one clocks, multiplexed only
// - strobe setup and hold is 1 clock, or 2 when timing bit 3 set
// - strobe width is width code plus one clocks
package dmau_pkg;

  // ==========================================
  // register map
  localparam logic [7:0] aux_addr     = 8'h8e;
  localparam logic [7:0] timing_addr  = 8'h8f;
  localparam logic [7:0] psw_addr     = 8'h0d0;
  localparam logic [7:0] p0_addr      = 8'h80;
  localparam logic [7:0] p2_addr      = 8'h0a0;

  // ==========================================
  // field positions and reset values
  localparam int         sel_bit       = 1;
  localparam int         fast_bit      = 3;
  localparam int         mode_bit      = 7;
  localparam int         sh_bit        = 3;
  localparam int         lw_lsb        = 4;
  localparam int         sw_lsb        = 0;
  localparam int         bank_lsb      = 3;
  localparam logic [7:0] aux_wmask     = 8'h0fe;
  localparam logic [7:0] timing_wmask  = 8'h0bf;
  localparam logic [7:0] aux_reset     = 8'h00;
  localparam logic [7:0] timing_reset  = 8'h00;
  localparam logic [7:0] port_reset    = 8'h0ff;
  localparam logic [7:0] upper_base    = 8'h80;
  localparam logic [7:0] bit_area_base = 8'h20;
  localparam logic [15:0] onchip_expanded_ram_top     = 16'h03ff;
  localparam int         onchip_expanded_ram_depth    = 1024;

  typedef enum {st_idle, st_ale_hi, st_ale_lo, st_setup, st_strobe, st_hold, st_done} phase_t;

  // one core request to data memory
  typedef struct packed {
    logic        direct;    // direct addressing
    logic        is_bit;    // single-bit operation
    logic        is_reg;    // working-register form, addr[2:0] is register number
    logic        ext;       // move-external access
    logic        wide;      // 16-bit pointer address
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        bit_val;
  } mem_req_t;

  typedef struct packed {
    logic       p0_oe;
    logic [7:0] p0_out;
    logic [7:0] p2_out;
    logic       ale;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic       strobe_fast_drive;
  } ext_pins_t;

endpackage : dmau_pkg

// File: sim/data_memory_access_unit_asserts.sv
// checker for the data memory access unit pins and register port
// assumes binding onto the design top, one clock domain
`timescale 1ns/1ps
module data_memory_access_unit_asserts (
  input wire logic mclk, reset_n, busy, reg_rd,
  input wire logic [7:0] reg_addr, reg_rdata,
  input wire dmau_pkg::ext_pins_t pins
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_strobes_exclusive: assert property (pins.read_strobe_n || pins.write_strobe_n)
    else $error("both strobes low");
  a_ale_no_strobe: assert property (pins.ale |-> pins.read_strobe_n && pins.write_strobe_n)
    else $error("strobe during latch pulse");
  a_wr_drives_bus: assert property (!pins.write_strobe_n |-> pins.p0_oe ##1 pins.p0_oe)
    else $error("write data not held");
  a_wr_data_stable: assert property (!pins.write_strobe_n [*2] |-> $stable(pins.p0_out))
    else $error("write data moved");
  a_rd_bus_free: assert property (!pins.read_strobe_n |-> !pins.p0_oe)
    else $error("bus driven in read");
  a_high_addr_held: assert property (!(pins.read_strobe_n && pins.write_strobe_n)
    |-> $stable(pins.p2_out))
    else $error("high address moved");
  a_reserved_zero: assert property (reg_rd && reg_addr == 8'h8f |=> !reg_rdata[6])
    else $error("reserved bit set");
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:60] !busy)
    else $error("access never ends");
  c_ext_write: cover property ($rose(pins.write_strobe_n));
  c_ext_read: cover property ($rose(pins.read_strobe_n));
  c_latch: cover property ($fell(pins.ale));
endmodule : data_memory_access_unit_asserts

// File: sim/ext_sram_model.sv
// external memory with address latch on the far side of the pins
`timescale 1ns/1ps
module ext_sram_model (input wire dmau_pkg::ext_pins_t pins, output logic [7:0] p0_in);
  logic [7:0] mem [0:255];
  logic [7:0] lat = 8'h00;
  always @(negedge pins.ale) lat = pins.p0_out;
  always @(posedge pins.write_strobe_n) mem[lat] = pins.p0_out;
  // released bus shows a changing value, not the last one
  always_comb p0_in = !pins.read_strobe_n ? mem[lat] : ~lat;
endmodule : ext_sram_model

// File: sim/data_memory_access_unit_tb_top.sv
// testbench: register port, external writes and reads at three timings
`timescale 1ns/1ps
module data_memory_access_unit_tb_top;
  logic mclk = 0, reset_n = 0, req_valid = 0, reg_wr = 0, reg_rd = 0, busy, rsp_valid;
  logic [7:0] reg_addr = 0, reg_wdata = 0, p0_in, reg_rdata, rsp_data;
  dmau_pkg::mem_req_t req = '0;
  dmau_pkg::ext_pins_t pins;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  always #20 mclk = ~mclk;
  data_memory_access_unit u_dut(.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .busy(busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .p0_in(p0_in), .pins(pins));
  ext_sram_model u_mem(.pins(pins), .p0_in(p0_in));
  task chk(logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task rg(logic w, logic [7:0] a, d);
    @(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= w; reg_rd <= !w;
    @(posedge mclk); reg_wr <= 0; reg_rd <= 0;
    #1 if (!w) chk(reg_rdata, d);
  endtask : rg
  logic [7:0] got, page;
  int busy_n, act_n, ale_n;
  // one core request; f is {direct, is_bit, is_reg}; measures busy and pins
  task acc(logic e, logic wd, logic w, logic [15:0] a, logic [7:0] d, logic [2:0] f,
    logic b);
    @(posedge mclk);
    req <= '{f[2], f[1], f[0], e, wd, w, a, d, b};
    req_valid <= 1'b1;
    @(posedge mclk);
    req_valid <= 1'b0;
    busy_n = 0;
    act_n = 0;
    ale_n = 0;
    got = 8'h00;
    for (int i = 0; i < 60; i++) begin
      #1;
      if (busy === 1'b1) busy_n++;
      if (pins.ale === 1'b1) ale_n++;
      if (pins.ale !== 1'b0 || pins.read_strobe_n !== 1'b1 || pins.write_strobe_n !== 1'b1)
        act_n++;
      if (pins.read_strobe_n === 1'b0 || pins.write_strobe_n === 1'b0) page = pins.p2_out;
      if (rsp_valid === 1'b1) begin
        got = rsp_data;
        break;
      end
      @(posedge mclk);
    end
    chk({7'h00, rsp_valid}, 8'h01);
  endtask : acc
  task t_regs;
    rg(1, 8'h8e, 8'h0b);
    rg(0, 8'h8e, 8'h0a);
    chk({7'h00, pins.strobe_fast_drive}, 8'h01);
    rg(1, 8'h8f, 8'h3f);
    rg(0, 8'h8f, 8'h3f);
    rg(1, 8'hd0, 8'h08);
    rg(0, 8'hd0, 8'h08);
    rg(1, 8'ha0, 8'h07);
    rg(0, 8'ha0, 8'h07);
  endtask : t_regs
  task t_internal;
    acc(0, 0, 1, 16'h0030, 8'h5a, 3'b100, 1'b0);
    acc(0, 0, 0, 16'h0030, 8'h00, 3'b000, 1'b0);
    chk(got, 8'h5a);
    acc(0, 0, 1, 16'h0090, 8'hc3, 3'b000, 1'b0);
    acc(0, 0, 0, 16'h00a0, 8'h00, 3'b100, 1'b0);
    chk(got, 8'h07);
    acc(0, 0, 0, 16'h0090, 8'h00, 3'b000, 1'b0);
    chk(got, 8'hc3);
    acc(0, 0, 1, 16'h0003, 8'h77, 3'b001, 1'b0);
    acc(0, 0, 0, 16'h000b, 8'h00, 3'b100, 1'b0);
    chk(got, 8'h77);
    acc(0, 0, 1, 16'h0021, 8'h00, 3'b100, 1'b0);
    acc(0, 0, 1, 16'h0009, 8'h00, 3'b110, 1'b1);
    acc(0, 0, 0, 16'h0021, 8'h00, 3'b100, 1'b0);
    chk(got, 8'h02);
    acc(0, 0, 0, 16'h0009, 8'h00, 3'b110, 1'b0);
    chk(got, 8'h01);
    acc(0, 0, 1, 16'h00a3, 8'h00, 3'b110, 1'b1);
    rg(0, 8'ha0, 8'h0f);
  endtask : t_internal
  task t_onchip_expanded_ram;
    rg(1, 8'h8e, 8'h08);
    acc(1, 1, 1, 16'h0123, 8'h69, 3'b000, 1'b0);
    acc(1, 1, 0, 16'h0123, 8'h00, 3'b000, 1'b0);
    chk(got, 8'h69);
    chk(8'(act_n), 8'h00);
    chk(8'(busy_n), 8'h00);
    rg(1, 8'h8e, 8'h0a);
  endtask : t_onchip_expanded_ram
  task t_ext(logic [7:0] t, logic [7:0] a, logic [7:0] d);
    int l;
    int x;
    l = t[7] ? 0 : int'(t[5:4]) + 1;
    x = 2 * l + 2 * (int'(t[3]) + 1) + int'(t[2:0]) + 2;
    rg(1, 8'h8f, t);
    rg(1, 8'h80, 8'h55);
    acc(1, 1, 1, {8'h12, a}, d, 3'b000, 1'b0);
    chk(8'(busy_n), 8'(x));
    chk(8'(ale_n), 8'(l));
    chk(page, 8'h12);
    rg(0, 8'h80, 8'hff);
    acc(1, 1, 0, {8'h12, a}, 8'h00, 3'b000, 1'b0);
    chk(got, d);
    acc(1, 0, 0, {8'h00, a}, 8'h00, 3'b000, 1'b0);
    chk(page, 8'h0f);
    chk(got, d);
  endtask : t_ext
  task summarize;
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  always @(posedge mclk) if (++cyc > 3000) begin error_cnt++; summarize; end
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs;
    t_internal;
    t_onchip_expanded_ram;
    t_ext(8'h3f, 8'h5a, 8'ha5);
    t_ext(8'h00, 8'h33, 8'h3c);
    t_ext(8'h80, 8'h44, 8'h96);
    summarize;
  end
endmodule : data_memory_access_unit_tb_top
bind data_memory_access_unit data_memory_access_unit_asserts u_chk(.mclk(mclk),
  .reset_n(reset_n), .busy(busy), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .pins(pins));
